// ==== rtl/jisp_pkg.sv ====
package jisp_pkg;

  // register offset of the port-enable control register (byte address)
  localparam logic [7:0] JISP_PEN_ADDR    = 8'hC7;
  localparam int         JISP_PEN_BIT     = 0;
  localparam logic [7:0] JISP_PEN_RESET   = 8'h00;
  localparam logic [7:0] JISP_PEN_MASK    = 8'h01;

  // link command opcodes carried by the 8-bit instruction register
  localparam logic [7:0] JISP_OP_ON       = 8'h01;
  localparam logic [7:0] JISP_OP_OFF      = 8'h02;
  localparam logic [7:0] JISP_OP_CLEAR    = 8'h03;
  localparam logic [7:0] JISP_OP_CHIPERA  = 8'h04;
  localparam logic [7:0] JISP_OP_SECERA   = 8'h05;
  localparam logic [7:0] JISP_OP_PROG     = 8'h06;
  localparam logic [7:0] JISP_OP_READ     = 8'h07;
  localparam logic [7:0] JISP_OP_VERIFY   = 8'h08;
  localparam logic [7:0] JISP_OP_SEC2WR   = 8'h09;
  localparam logic [7:0] JISP_OP_NOP      = 8'hFF;

  // option bit of the enable command's payload: open-drain extensions
  localparam int         JISP_OD_BIT      = 0;

  // blank state values
  localparam logic [7:0] JISP_BLANK_DATA  = 8'hFF;
  localparam logic       JISP_CFG_BLANK   = 1'b0;

  // command handed from the link domain to the system domain
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg;
  } jisp_cmd_t;

  // request to the flash engine
  typedef struct packed {
    logic       prog;
    logic       sec_erase;
    logic       chip_erase;
    logic       sec2_write;
    logic [7:0] arg;
  } jisp_flash_req_t;

endpackage

// ==== rtl/jisp_sync.sv ====
`timescale 1ns/10ps
// two-flop level synchroniser, first flop read only by the second
module jisp_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  initial
  begin
    if (W < 1) $error("width must be at least one");
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

// ==== rtl/jisp_link.sv ====
`timescale 1ns/10ps
// link-clock shifter: 8-bit instruction then 8-bit argument on tdi,
// loaded at update; tdo returns a captured byte lsb first
module jisp_link
  import jisp_pkg::*;
(
  input  wire logic      i_tck,
  input  wire logic      i_rst,
  input  wire logic      i_tms,
  input  wire logic      i_tdi,
  input  wire logic [7:0] i_rd_data,
  output logic           o_tdo,
  output logic           o_tdo_oe_n,
  output logic           o_cmd_tgl,
  output jisp_pkg::jisp_cmd_t o_cmd
);

  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic [7:0]  out_q;
  logic        tgl_q;
  jisp_cmd_t   cmd_q;
  logic        full;

  assign full = (cnt_q == 5'd16);

  // tms high frames the shift; falling tms with a full word is update
  always_ff @(posedge i_tck or posedge i_rst)
  begin
    if (i_rst)
    begin
      sh_q  <= '0;
      cnt_q <= '0;
      out_q <= '0;
      tgl_q <= 1'b0;
      cmd_q <= '0;
    end
    else if (i_tms)
    begin
      sh_q  <= {i_tdi, sh_q[15:1]};
      cnt_q <= full ? cnt_q : cnt_q + 5'd1;
      out_q <= (cnt_q == 5'd0) ? i_rd_data : {1'b0, out_q[7:1]};
    end
    else
    begin
      if (full)
      begin
        cmd_q <= '{op: sh_q[7:0], arg: sh_q[15:8]};
        tgl_q <= ~tgl_q;
      end
      cnt_q <= '0;
    end
  end

  assign o_tdo      = out_q[0];
  assign o_tdo_oe_n = ~i_tms;
  assign o_cmd_tgl  = tgl_q;
  assign o_cmd      = cmd_q;

endmodule

// ==== rtl/jisp_top.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: extension outputs stay inactive until the enable command arrives.
// R2: error output goes low when sector erase or byte program fails.
// R3: error stays low until clear command, or reset after disable command.
// R4: status output high while in read mode.
// R5: status output low during any program or erase cycle.
// R6: status output low while secondary flash is being written.
// R7: enable command may select open-drain extensions for wired-OR.
// R8: secured device refuses every content read.
// R9: secured device accepts only full chip erase from the port.
// R10: secured device blocks other program, erase and verify commands.
// R11: finished chip erase clears security and leaves the part blank.
// R12: erase of a sector whose protect bit is set is rejected.
// R13: blank state reads all memory and logic bits as one.
// R14: blank state holds all configuration bits at zero.
// R15: port-enable bit zero turns the port on when one, off when zero.
// R16: software writes zero to port-enable bits one through seven.
// R17: dedicated-pin mode lets port work whatever the reset input does.
// R18: register-only enable: reset aborts and blocks port operations.
// R19: port on if dedicate bit, register bit or product term is set.
// R20: device reset and the microcontroller both clear the enable bit.
module jisp_top
  import jisp_pkg::*;
#(
  parameter int NSEC = 12
)
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_dev_rst,
  input  wire logic             i_tck,
  input  wire logic             i_tms,
  input  wire logic             i_tdi,
  input  wire logic             i_reg_wr,
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic [7:0]       i_reg_wdata,
  output logic      [7:0]       o_reg_rdata,
  input  wire logic             i_nvm_dedicate,
  input  wire logic             i_port_select_term,
  input  wire logic             i_secured,
  input  wire logic [NSEC-1:0]  i_sec_protect,
  input  wire logic [7:0]       i_mem_rdata,
  input  wire logic             i_flash_busy,
  input  wire logic             i_flash_done,
  input  wire logic             i_flash_fail,
  output jisp_pkg::jisp_flash_req_t o_flash_req,
  output logic                  o_flash_req_vld,
  output logic                  o_clear_security,
  output logic                  o_port_on,
  output logic                  o_tdo,
  output logic                  o_tdo_oe_n,
  output logic                  o_flash_status_out,
  output logic                  o_flash_status_oe_n,
  output logic                  o_flash_error_out,
  output logic                  o_flash_error_oe_n
);

  initial
  begin
    if (NSEC < 1 || NSEC > 256) $error("sector count out of range");
  end

  typedef enum logic [3:0] {
    JISP_IDLE = 4'b0001,
    JISP_BUSY = 4'b0010,
    JISP_ERA  = 4'b0100,
    JISP_WR2  = 4'b1000
  } jisp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // port enable register and pin enable

  logic        pen_q;
  logic        port_on;
  logic        link_rst;
  logic        reg_sel;

  assign reg_sel = (i_reg_addr == JISP_PEN_ADDR);

  // device reset clears the bit; upper bits ignored, read back as zero
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pen_q <= JISP_PEN_RESET[JISP_PEN_BIT]; // R14 R20
    else if (i_dev_rst)
      pen_q <= 1'b0; // R20
    else if (i_reg_wr && reg_sel)
      pen_q <= i_reg_wdata[JISP_PEN_BIT]; // R15 R20 R16
  end

  assign o_reg_rdata = reg_sel ? ({7'h00, pen_q} & JISP_PEN_MASK) : 8'h00;

  // three enable sources are ored together
  assign port_on   = i_nvm_dedicate | pen_q | i_port_select_term; // R19
  assign o_port_on = port_on;

  // reset only touches the port when it is not dedicated by the nvm bit;
  // the link is also held while the port is off
  assign link_rst = i_sys_rst | ~port_on
                  | (i_dev_rst & ~i_nvm_dedicate); // R17 R18

  ////////////////////////////////////////////////////////////////////////////
  // link domain and command crossing

  jisp_cmd_t   lcmd;
  logic        ltgl;
  logic        tgl_s;
  logic        tgl_q;
  logic        cmd_stb;
  jisp_cmd_t   cmd;
  logic [7:0]  rd_byte_q;
  logic        abort;

  jisp_link u_link (
    .i_tck      (i_tck),
    .i_rst      (link_rst),
    .i_tms      (i_tms),
    .i_tdi      (i_tdi),
    .i_rd_data  (rd_byte_q),
    .o_tdo      (o_tdo),
    .o_tdo_oe_n (o_tdo_oe_n),
    .o_cmd_tgl  (ltgl),
    .o_cmd      (lcmd)
  );

  jisp_sync #(.W(1)) u_sync (
    .i_clk (i_sys_clk),
    .i_rst (i_sys_rst),
    .i_d   (ltgl),
    .o_q   (tgl_s)
  );

  // command word is stable for many tck edges after the toggle settles
  assign cmd_stb = tgl_s ^ tgl_q;
  assign cmd     = lcmd;
  assign abort   = i_dev_rst & ~i_nvm_dedicate & ~i_nvm_dedicate; // R18

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      tgl_q <= 1'b0;
    else
      tgl_q <= tgl_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode with security and sector protection gating

  logic        is_on;
  logic        is_off;
  logic        is_clr;
  logic        is_chip;
  logic        is_sec;
  logic        is_prog;
  logic        is_read;
  logic        is_wr2;
  logic        sec_prot;
  logic        go;
  logic        st_idle;

  function automatic logic op_is(input jisp_cmd_t c, input logic [7:0] op);
    return c.op == op;
  endfunction

  assign st_idle = 1'b1;
  assign go      = cmd_stb & ~abort;
  assign is_on   = go & op_is(cmd, JISP_OP_ON);
  assign is_off  = go & op_is(cmd, JISP_OP_OFF);
  assign is_clr  = go & op_is(cmd, JISP_OP_CLEAR);
  assign is_chip = go & op_is(cmd, JISP_OP_CHIPERA); // R9
  // secured part refuses all other program, erase, verify, read
  assign sec_prot = (cmd.arg < NSEC) ? i_sec_protect[cmd.arg[7:0] % NSEC]
                                     : 1'b1;
  assign is_sec  = go & ~i_secured & op_is(cmd, JISP_OP_SECERA)
                 & ~sec_prot; // R10 R12
  assign is_prog = go & ~i_secured & op_is(cmd, JISP_OP_PROG); // R10
  assign is_wr2  = go & ~i_secured & op_is(cmd, JISP_OP_SEC2WR); // R10
  assign is_read = go & ~i_secured
                 & (op_is(cmd, JISP_OP_READ) | op_is(cmd, JISP_OP_VERIFY));

  ////////////////////////////////////////////////////////////////////////////
  // flash sequencing

  jisp_state_t st_q;
  jisp_state_t st_d;
  logic        ext_on_q;
  logic        od_q;
  logic        off_seen_q;
  logic        err_q;
  logic        launch;

  assign launch = (st_q == JISP_IDLE) & (is_chip | is_sec | is_prog | is_wr2);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      JISP_IDLE:
        if (is_chip)
          st_d = JISP_ERA;
        else if (is_wr2)
          st_d = JISP_WR2;
        else if (is_sec | is_prog)
          st_d = JISP_BUSY;
      JISP_BUSY, JISP_ERA, JISP_WR2:
        if (i_flash_done | abort)
          st_d = JISP_IDLE;
      default:
        st_d = JISP_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st_q <= JISP_IDLE;
    else
      st_q <= st_d;
  end

  assign o_flash_req_vld  = launch;
  assign o_flash_req      = '{prog: is_prog, sec_erase: is_sec,
                              chip_erase: is_chip, sec2_write: is_wr2,
                              arg: cmd.arg};
  // finished chip erase unsecures the part
  assign o_clear_security = (st_q == JISP_ERA) & i_flash_done
                          & ~i_flash_fail; // R11

  // read data: refused reads return blank ones
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rd_byte_q <= JISP_BLANK_DATA; // R13
    else if (go & op_is(cmd, JISP_OP_READ))
      rd_byte_q <= is_read ? i_mem_rdata : JISP_BLANK_DATA; // R8
  end

  ////////////////////////////////////////////////////////////////////////////
  // extension enable, open-drain option and sticky error

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ext_on_q   <= JISP_CFG_BLANK;
      od_q       <= JISP_CFG_BLANK;
      off_seen_q <= 1'b0;
    end
    else if (is_on)
    begin
      ext_on_q   <= 1'b1; // R1
      od_q       <= cmd.arg[JISP_OD_BIT]; // R7
      off_seen_q <= 1'b0;
    end
    else if (is_off)
      off_seen_q <= 1'b1;
    else if (i_dev_rst & off_seen_q)
      ext_on_q   <= 1'b0;
  end

  // a failure in the same cycle as the clear wins; flag is sticky
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      err_q <= 1'b0;
    else if (i_flash_done & i_flash_fail
             & ((st_q == JISP_BUSY) | (st_q == JISP_ERA)))
      err_q <= 1'b1; // R2
    else if (is_clr | (i_dev_rst & off_seen_q))
      err_q <= 1'b0; // R3
  end

  ////////////////////////////////////////////////////////////////////////////
  // extension pins: push-pull or open-drain, enable active low

  logic        stat_lvl;
  logic        err_lvl;

  // low while programming, erasing or writing the secondary flash
  assign stat_lvl = (st_q == JISP_IDLE) & ~i_flash_busy; // R4 R5 R6
  assign err_lvl  = ~err_q; // R2

  assign o_flash_status_out  = od_q ? 1'b0 : stat_lvl;
  assign o_flash_status_oe_n = ~ext_on_q | (od_q & stat_lvl); // R1 R7
  assign o_flash_error_out   = od_q ? 1'b0 : err_lvl;
  assign o_flash_error_oe_n  = ~ext_on_q | (od_q & err_lvl); // R1 R7

endmodule

// ==== test/jisp_jtag_ctrl.sv ====
`timescale 1ns/10ps
// programming cable model: drives the link clock only inside a frame
module jisp_jtag_ctrl
(
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  // first byte seen on tdo during the last frame, lsb first
  logic [7:0] rx = 8'h00;
  initial
  begin
    o_tck = 1'h0;
    o_tms = 1'h0;
    o_tdi = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // opcode then argument lsb first, then one update edge; the clock
  // stands still between frames, so no idle edges reach the shifter
  task automatic send(input logic [7:0] op, input logic [7:0] arg);
    logic [15:0] w;
    w = {arg, op};
    #2;
    o_tms = 1'h1;
    for (int k = 0; k < 16; k++)
    begin
      o_tdi = w[k];
      #3 o_tck = 1'h1;
      #3 o_tck = 1'h0;
      // tdo settled half a period after the rising edge that moved it
      if (k < 8) rx[k] = i_tdo;
    end
    o_tms = 1'h0;
    #3 o_tck = 1'h1;
    #3 o_tck = 1'h0;
    o_tdi = ~o_tdi; // released data never holds the last bit
  endtask
endmodule

// ==== test/jisp_top_sva.sv ====
`timescale 1ns/10ps
module jisp_top_sva
  import jisp_pkg::*;
(
  input wire logic            i_sys_clk,
  input wire logic            i_sys_rst,
  input wire logic            i_dev_rst,
  input wire logic            i_reg_wr,
  input wire logic [7:0]      i_reg_addr,
  input wire logic [7:0]      i_reg_wdata,
  input wire logic [7:0]      o_reg_rdata,
  input wire logic            i_nvm_dedicate,
  input wire logic            i_port_select_term,
  input wire logic            i_secured,
  input wire logic            i_flash_busy,
  input wire logic            i_flash_done,
  input wire logic            i_flash_fail,
  input wire jisp_flash_req_t o_flash_req,
  input wire logic            o_flash_req_vld,
  input wire logic            o_clear_security,
  input wire logic            o_port_on,
  input wire logic            o_flash_status_out,
  input wire logic            o_flash_status_oe_n,
  input wire logic            o_flash_error_out,
  input wire logic            o_flash_error_oe_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // good completion, kept one cycle since the pulse may be registered
  wire  pen_sel = (i_reg_addr == JISP_PEN_ADDR);
  wire  good_d  = i_flash_done & ~i_flash_fail;
  logic good_q;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    if (i_sys_rst)
      good_q <= 1'h0;
    else
      good_q <= good_d;
  //////////////////////////////////////////////////////////////////////
  sequence s_fail;
    i_flash_done && i_flash_fail && !o_flash_error_oe_n;
  endsequence
  sequence s_busy;
    i_flash_busy [*3];
  endsequence
  a_port_or: assert property (
    pen_sel |-> o_port_on == (i_nvm_dedicate | i_port_select_term
      | o_reg_rdata[0]))
    else $error("port enable differs from its three sources");
  a_upper_zero: assert property (
    o_reg_rdata[7:1] == 7'h00)
    else $error("unused enable bits read nonzero");
  a_en_write: assert property (
    (i_reg_wr && pen_sel && !i_dev_rst ##1 pen_sel && !i_dev_rst)
      |-> o_reg_rdata[0] == $past(i_reg_wdata[0]))
    else $error("enable bit missed a write");
  a_devrst_clr: assert property (
    ((i_dev_rst && !i_reg_wr) [*3] ##1 pen_sel) |-> !o_reg_rdata[0])
    else $error("device reset left the enable bit set");
  a_busy_low: assert property (
    s_busy |-> o_flash_status_oe_n || !o_flash_status_out)
    else $error("status high while flash busy");
  a_err_set: assert property (
    s_fail |-> ##[1:4] !o_flash_error_out)
    else $error("failed operation did not pull error low");
  a_ext_need: assert property (
    $fell(o_flash_status_oe_n) |-> o_port_on)
    else $error("status driven with the port off");
  a_sec_only: assert property (
    o_flash_req_vld && i_secured |-> o_flash_req.chip_erase
      && !o_flash_req.prog && !o_flash_req.sec_erase)
    else $error("secured part launched a non chip erase");
  a_clr_sec: assert property (
    o_clear_security |-> good_d || good_q)
    else $error("security cleared without good erase");
endmodule
bind jisp_top jisp_top_sva u_sva (.*);

// ==== test/test_jtag_isp_status_security.sv ====
`timescale 1ns/10ps
module test_jtag_isp_status_security;
  import jisp_pkg::*;
  logic            i_sys_clk = 1'h0;
  logic            i_sys_rst = 1'h1;
  logic            i_dev_rst = 1'h0;
  logic            i_reg_wr = 1'h0;
  logic [7:0]      i_reg_addr = JISP_PEN_ADDR;
  logic [7:0]      i_reg_wdata = 8'h00;
  logic            i_nvm_dedicate = 1'h0;
  logic            i_port_select_term = 1'h0;
  logic            i_secured = 1'h0;
  logic [11:0]     i_sec_protect = 12'h000;
  logic [7:0]      i_mem_rdata = 8'hFF;
  logic            i_flash_busy = 1'h0;
  logic            i_flash_done = 1'h0;
  logic            i_flash_fail = 1'h0;
  logic            i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n;
  logic [7:0]      o_reg_rdata, k;
  jisp_flash_req_t o_flash_req;
  logic            o_flash_req_vld, o_clear_security, o_port_on, c;
  logic            o_flash_status_out, o_flash_status_oe_n;
  logic            o_flash_error_out, o_flash_error_oe_n;
  int              err_count = 0;
  int              checked = 0;
  jisp_top #(.NSEC(12)) DUT (.*);
  jisp_jtag_ctrl PM (.i_tdo(o_tdo), .o_tck(i_tck), .o_tms(i_tms),
    .o_tdi(i_tdi));
  initial
  begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    i_reg_wr    <= 1'h1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    cyc(1);
    i_reg_wr    <= 1'h0;
  endtask
  // one command, then play the flash: busy, done, optional failure;
  // kind packs {prog,sec_erase,chip_erase,sec2_write}, cs any clear
  task automatic fop(input logic [7:0] op, input logic [7:0] arg,
    input logic f, output logic [7:0] kind, output logic cs);
    kind = 8'h00;
    cs   = 1'h0;
    PM.send(op, arg);
    for (int n = 0; n < 30 && kind == 8'h00; n++)
    begin
      cyc(1);
      #1 if (o_flash_req_vld === 1'h1)
        kind = {4'h0, o_flash_req.prog, o_flash_req.sec_erase,
          o_flash_req.chip_erase, o_flash_req.sec2_write};
    end
    if (kind != 8'h00)
    begin
      cyc(1);
      i_flash_busy <= 1'h1;
      cyc(3);
      #1 chk({7'h00, o_flash_status_out}, 8'h00);
      cyc(1);
      i_flash_busy <= 1'h0;
      i_flash_done <= 1'h1;
      i_flash_fail <= f;
      #1 cs = o_clear_security;
      cyc(1);
      i_flash_done <= 1'h0;
      i_flash_fail <= 1'h0;
      repeat (4)
      begin
        #1 cs |= o_clear_security;
        cyc(1);
      end
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reg;
    #1 chk(o_reg_rdata, 8'h00);
    chk({6'h00, o_flash_status_oe_n, o_flash_error_oe_n}, 8'h03);
    wr(JISP_PEN_ADDR, 8'h01);
    #1 chk({7'h00, o_port_on}, 8'h01);
    chk(o_reg_rdata, 8'h01);
    wr(8'hC6, 8'h00);
    #1 chk(o_reg_rdata, 8'h00);
    wr(JISP_PEN_ADDR, 8'h00);
    #1 chk({7'h00, o_port_on}, 8'h00);
    i_nvm_dedicate <= 1'h1;
    cyc(1);
    #1 chk({7'h00, o_port_on}, 8'h01);
    i_nvm_dedicate     <= 1'h0;
    i_port_select_term <= 1'h1;
    cyc(1);
    #1 chk({7'h00, o_port_on}, 8'h01);
    i_port_select_term <= 1'h0;
    wr(JISP_PEN_ADDR, 8'h01);
    i_dev_rst <= 1'h1;
    cyc(4);
    i_dev_rst <= 1'h0;
    #1 chk(o_reg_rdata, 8'h00);
    wr(JISP_PEN_ADDR, 8'h01);
    $display("test registers done");
  endtask
  task automatic t_ext;
    PM.send(JISP_OP_ON, 8'h00);
    cyc(8);
    #1 chk({6'h00, o_flash_status_oe_n, o_flash_status_out}, 8'h01);
    fop(JISP_OP_PROG, 8'h05, 1'h1, k, c);
    chk(k, 8'h08);
    cyc(2);
    #1 chk({7'h00, o_flash_error_out}, 8'h00);
    PM.send(JISP_OP_CLEAR, 8'h00);
    cyc(8);
    #1 chk({7'h00, o_flash_error_out}, 8'h01);
    fop(JISP_OP_SEC2WR, 8'h00, 1'h0, k, c);
    chk(k, 8'h01);
    #1 chk({7'h00, o_flash_status_out}, 8'h01);
    PM.send(JISP_OP_ON, 8'h01);
    cyc(8);
    #1 chk({4'h0, o_flash_status_oe_n, o_flash_status_out,
      o_flash_error_oe_n, o_flash_error_out}, 8'h0A);
    PM.send(JISP_OP_ON, 8'h00);
    cyc(8);
    $display("test extensions done");
  endtask
  task automatic t_secure;
    i_secured     <= 1'h1;
    i_sec_protect <= 12'h004;
    fop(JISP_OP_PROG, 8'h01, 1'h0, k, c);
    chk(k, 8'h00);
    fop(JISP_OP_SECERA, 8'h03, 1'h0, k, c);
    chk(k, 8'h00);
    fop(JISP_OP_CHIPERA, 8'h00, 1'h0, k, c);
    chk({k[3:0], 3'h0, c}, 8'h21);
    i_secured <= 1'h0;
    fop(JISP_OP_SECERA, 8'h02, 1'h0, k, c);
    chk(k, 8'h00);
    fop(JISP_OP_SECERA, 8'h03, 1'h0, k, c);
    chk(k, 8'h04);
    $display("test security done");
  endtask
  // a read frame then an idle frame that shifts the result back out
  task automatic t_read;
    i_mem_rdata <= 8'hA5;
    cyc(1);
    PM.send(JISP_OP_READ, 8'h00);
    cyc(8);
    PM.send(JISP_OP_NOP, 8'h00);
    chk(PM.rx, 8'hA5);
    cyc(1);
    i_secured <= 1'h1;
    cyc(1);
    PM.send(JISP_OP_READ, 8'h00);
    cyc(8);
    PM.send(JISP_OP_NOP, 8'h00);
    chk(PM.rx, JISP_BLANK_DATA);
    cyc(1);
    i_secured <= 1'h0;
    cyc(1);
    $display("test read done");
  endtask
  task automatic t_devrst;
    fop(JISP_OP_PROG, 8'h02, 1'h1, k, c);
    chk(k, 8'h08);
    PM.send(JISP_OP_OFF, 8'h00);
    cyc(8);
    #1 chk({7'h00, o_flash_error_out}, 8'h00);
    cyc(1);
    i_dev_rst <= 1'h1;
    fop(JISP_OP_PROG, 8'h02, 1'h0, k, c);
    chk(k, 8'h00);
    i_nvm_dedicate <= 1'h1;
    fop(JISP_OP_PROG, 8'h02, 1'h0, k, c);
    chk(k, 8'h08);
    #1 chk({5'h00, o_flash_status_oe_n, o_flash_error_oe_n,
      o_flash_error_out}, 8'h07);
    i_dev_rst <= 1'h0;
    $display("test device reset done");
  endtask
  // long enough for every frame and flash cycle several times over
  initial
  begin
    #200000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    cyc(8);
    i_sys_rst <= 1'h0;
    cyc(2);
    t_reg();
    t_ext();
    t_secure();
    t_read();
    t_devrst();
    wrap_up();
  end
endmodule
